/* File: include/sct_pkg.sv */
`default_nettype none
package sct_pkg;
  // register indices; byte address is index times four
  localparam logic [15:0] IDX_BGT    = 16'hFE16;
  localparam logic [15:0] IDX_EGT    = 16'hFE17;
  localparam logic [15:0] IDX_BWT3   = 16'hFE18;
  localparam logic [15:0] IDX_BWT2   = 16'hFE19;
  localparam logic [15:0] IDX_BWT1   = 16'hFE1A;
  localparam logic [15:0] IDX_BWT0   = 16'hFE1B;
  localparam logic [15:0] IDX_CWT1   = 16'hFE1C;
  localparam logic [15:0] IDX_CWT0   = 16'hFE1D;
  localparam logic [15:0] IDX_ATR1   = 16'hFE1F;
  localparam logic [15:0] IDX_ATR0   = 16'hFE20;
  localparam logic [15:0] IDX_FIRST_CHAR_TIMEOUT_LIMIT   = 16'hFE21;
  localparam logic [15:0] IDX_RLEN   = 16'hFE22;
  localparam logic [15:0] IDX_CTRL   = 16'hFE24;
  localparam logic [15:0] IDX_STAT   = 16'hFE25;
  localparam logic [15:0] IDX_ETUDIV = 16'hFE26;

  localparam logic [7:0]  RST_BGT    = 8'h16;
  localparam logic [7:0]  RST_EGT    = 8'h0C;
  localparam logic [7:0]  RST_RLEN   = 8'h70;
  localparam logic [12:0] RST_ETUDIV = 13'h02E8;

  // control bit positions
  localparam int CTRL_T1    = 0;
  localparam int CTRL_ANS   = 1;
  localparam int CTRL_FCDET = 2;
  localparam int CTRL_HOLD  = 3;
  // status bit positions; bits 0 to 3 write one to clear, ST_RSTN and ST_TXOK are read only; BGT_EGT8 is bit 7 of BGT
  localparam int ST_WAIT = 0;
  localparam int ST_CHAR = 1;
  localparam int ST_ANS  = 2;
  localparam int ST_MUTE = 3;
  localparam int ST_RSTN = 4;
  localparam int ST_TXOK = 5;
  localparam int BGT_EGT8 = 7;

  localparam logic [8:0] MIN_GUARD_T0 = 9'h00C;
  localparam logic [8:0] MIN_GUARD_T1 = 9'h00B;

  typedef enum logic [1:0] {
    RS_HOLD  = 2'b00,
    RS_DELAY = 2'b01,
    RS_RUN   = 2'b10
  } sct_rst_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } sct_apb_req_type;

  typedef struct packed {
    logic waitTo;
    logic charTo;
    logic answerTo;
    logic firstCharTo;
  } sct_event_type;

  typedef struct packed {
    logic [7:0]        block_guard_time;
    logic [7:0]        egtLo;
    logic [27:0]       block_wait_limit;
    logic [15:0]       char_wait_limit;
    logic [15:0]       atr;
    logic [7:0]        first_char_timeout_limit;
    logic [7:0]        rlen;
    logic [3:0]        ctrl;
    logic [12:0]       etuDiv;
    logic [3:0]        stat;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [12:0]       divCnt;
    logic              etuTick;
    logic              ioMeta;
    logic              ioSync;
    logic              ioLast;
    logic              supMeta;
    logic              supSync;
    logic [8:0]        rxGap;
    logic [8:0]        txGap;
    logic              lastRx;
    logic [27:0]       bwtCnt;
    logic              bwtArm;
    logic [15:0]       cwtCnt;
    logic              cwtArm;
    logic [15:0]       atrCnt;
    logic              atrArm;
    logic [7:0]        tsCnt;
    logic              tsArm;
    logic [7:0]        rlCnt;
    sct_rst_state_type rstSt;
    sct_event_type     evt;
  } sct_state_type;
endpackage : sct_pkg
`default_nettype wire

/* File: rtl/sct_etu_guard.sv */
`default_nettype none
module sct_etu_guard (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // register bus
  input  wire sct_pkg::sct_apb_req_type apbReq,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // card pins
  input  wire logic                     ioIn,
  input  wire logic                     cardSupplyGood,
  output logic                          cardRstn,
  // character engine
  input  wire logic                     txBusy,
  input  wire logic                     txStart,
  input  wire logic                     breakSeen,
  output logic                          txAllow,
  // timeout events
  output var sct_pkg::sct_event_type    events
);
  sct_pkg::sct_state_type st;
  sct_pkg::sct_state_type nx;

  logic        setup;
  logic        wr;
  logic        hit;
  logic [15:0] idx;
  logic        rxStart;
  logic        t1;
  logic [8:0]  egt9;
  logic [8:0]  egtEff;
  logic [8:0]  minGuard;
  logic        guardOk;
  logic        relOk;
  logic [3:0]  setStat;
  logic [31:0] rdVal;

  assign setup    = apbReq.psel && !apbReq.penable;
  assign wr       = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign idx      = apbReq.paddr[17:2];
  assign t1       = st.ctrl[sct_pkg::CTRL_T1];
  assign egt9     = {st.block_guard_time[sct_pkg::BGT_EGT8], st.egtLo};
  assign minGuard = t1 ? sct_pkg::MIN_GUARD_T1 : sct_pkg::MIN_GUARD_T0;
  assign egtEff   = (egt9 < minGuard) ? minGuard : egt9;
  // first character after reception obeys block guard and extra guard, others extra guard only
  assign guardOk  = (!st.lastRx || st.rxGap >= {4'h0, st.block_guard_time[4:0]})
                 && (st.txGap >= egtEff);
  assign txAllow  = guardOk;
  assign rxStart  = st.ioLast && !st.ioSync && !txBusy;
  assign relOk    = st.supSync && !st.ctrl[sct_pkg::CTRL_HOLD];
  assign pready   = 1'b1;
  assign prdata   = st.prdata;
  assign pslverr  = st.pslverr;
  assign cardRstn = (st.rstSt == sct_pkg::RS_RUN);
  assign events   = st.evt;

  always_comb begin
    rdVal = 32'h0000_0000;
    hit   = 1'b1;
    case (idx)
      sct_pkg::IDX_BGT:    rdVal = {24'h0, st.block_guard_time[7], 2'b00, st.block_guard_time[4:0]};
      sct_pkg::IDX_EGT:    rdVal = {24'h0, st.egtLo};
      sct_pkg::IDX_BWT3:   rdVal = {28'h0, st.block_wait_limit[27:24]};
      sct_pkg::IDX_BWT2:   rdVal = {24'h0, st.block_wait_limit[23:16]};
      sct_pkg::IDX_BWT1:   rdVal = {24'h0, st.block_wait_limit[15:8]};
      sct_pkg::IDX_BWT0:   rdVal = {24'h0, st.block_wait_limit[7:0]};
      sct_pkg::IDX_CWT1:   rdVal = {24'h0, st.char_wait_limit[15:8]};
      sct_pkg::IDX_CWT0:   rdVal = {24'h0, st.char_wait_limit[7:0]};
      sct_pkg::IDX_ATR1:   rdVal = {24'h0, st.atr[15:8]};
      sct_pkg::IDX_ATR0:   rdVal = {24'h0, st.atr[7:0]};
      sct_pkg::IDX_FIRST_CHAR_TIMEOUT_LIMIT:   rdVal = {24'h0, st.first_char_timeout_limit};
      sct_pkg::IDX_RLEN:   rdVal = {24'h0, st.rlen};
      sct_pkg::IDX_CTRL:   rdVal = {28'h0, st.ctrl};
      sct_pkg::IDX_STAT:   rdVal = {26'h0, guardOk, cardRstn, st.stat};
      sct_pkg::IDX_ETUDIV: rdVal = {19'h0, st.etuDiv};
      default:             hit   = 1'b0;
    endcase
    if (apbReq.paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  always_comb begin
    nx         = st;
    setStat    = 4'h0;
    nx.evt     = '0;
    nx.etuTick = 1'b0;
    // registers
    if (setup) begin
      nx.prdata  = hit ? rdVal : 32'h0000_0000;
      nx.pslverr = !hit;
    end
    if (wr && hit) begin
      case (idx)
        sct_pkg::IDX_BGT:    nx.block_guard_time = {apbReq.pwdata[7], 2'b00, apbReq.pwdata[4:0]};
        sct_pkg::IDX_EGT:    nx.egtLo = apbReq.pwdata[7:0];
        sct_pkg::IDX_BWT3:   nx.block_wait_limit[27:24] = apbReq.pwdata[3:0];
        sct_pkg::IDX_BWT2:   nx.block_wait_limit[23:16] = apbReq.pwdata[7:0];
        sct_pkg::IDX_BWT1:   nx.block_wait_limit[15:8] = apbReq.pwdata[7:0];
        sct_pkg::IDX_BWT0:   nx.block_wait_limit[7:0] = apbReq.pwdata[7:0];
        sct_pkg::IDX_CWT1:   nx.char_wait_limit[15:8] = apbReq.pwdata[7:0];
        sct_pkg::IDX_CWT0:   nx.char_wait_limit[7:0] = apbReq.pwdata[7:0];
        sct_pkg::IDX_ATR1:   nx.atr[15:8] = apbReq.pwdata[7:0];
        sct_pkg::IDX_ATR0:   nx.atr[7:0] = apbReq.pwdata[7:0];
        sct_pkg::IDX_FIRST_CHAR_TIMEOUT_LIMIT:   nx.first_char_timeout_limit = apbReq.pwdata[7:0];
        sct_pkg::IDX_RLEN:   nx.rlen = apbReq.pwdata[7:0];
        sct_pkg::IDX_CTRL:   nx.ctrl = apbReq.pwdata[3:0];
        sct_pkg::IDX_ETUDIV: nx.etuDiv = apbReq.pwdata[12:0];
        default:             nx.ctrl = st.ctrl;
      endcase
    end
    // ETU divider; the divisor register holds two times Fi/Di
    if (st.divCnt + 13'h0001 >= st.etuDiv) begin
      nx.divCnt  = 13'h0000;
      nx.etuTick = 1'b1;
    end else begin
      nx.divCnt = st.divCnt + 13'h0001;
    end
    // pin synchronisers
    nx.ioMeta  = ioIn;
    nx.ioSync  = st.ioMeta;
    nx.ioLast  = st.ioSync;
    nx.supMeta = cardSupplyGood;
    nx.supSync = st.supMeta;
    // guard counters saturate so long idle never wraps below the limit
    if (st.etuTick) begin
      if (st.rxGap != 9'h1FF) begin
        nx.rxGap = st.rxGap + 9'h001;
      end
      if (st.txGap != 9'h1FF) begin
        nx.txGap = st.txGap + 9'h001;
      end
      nx.bwtCnt = st.bwtCnt + 28'h000_0001;
      nx.cwtCnt = st.cwtCnt + 16'h0001;
      nx.atrCnt = st.atrCnt + 16'h0001;
      nx.tsCnt  = st.tsCnt + 8'h01;
      if (st.bwtArm && st.bwtCnt == st.block_wait_limit) begin
        nx.bwtArm     = 1'b0;
        nx.evt.waitTo = 1'b1;
      end
      if (st.cwtArm && st.cwtCnt == st.char_wait_limit) begin
        nx.cwtArm     = 1'b0;
        nx.evt.charTo = 1'b1;
      end
      if (st.atrArm && st.atrCnt == st.atr) begin
        nx.atrArm       = 1'b0;
        nx.evt.answerTo = 1'b1;
      end
      if (st.tsArm && st.tsCnt == st.first_char_timeout_limit) begin
        nx.tsArm           = 1'b0;
        nx.evt.answerTo    = 1'b1;
        nx.evt.firstCharTo = 1'b1;
      end
    end
    if (t1 == 1'b0 && breakSeen) begin
      nx.txGap = 9'h000;
    end
    if (txStart) begin
      nx.txGap  = 9'h000;
      nx.lastRx = 1'b0;
      nx.bwtCnt = 28'h000_0000;
      nx.bwtArm = 1'b1;
    end
    if (rxStart) begin
      nx.rxGap  = 9'h000;
      nx.lastRx = 1'b1;
      nx.bwtCnt = 28'h000_0000;
      nx.bwtArm = !t1;
      nx.cwtCnt = 16'h0000;
      nx.cwtArm = 1'b1;
      nx.tsArm  = 1'b0;
      if (st.ctrl[sct_pkg::CTRL_ANS] && !st.atrArm && st.atrCnt == 16'h0000) begin
        nx.atrArm = 1'b1;
        nx.atrCnt = 16'h0000;
      end
    end
    // answer timer starts at the first received start edge after the flag is raised
    if (!st.ctrl[sct_pkg::CTRL_ANS]) begin
      nx.atrArm = 1'b0;
      nx.atrCnt = 16'h0000;
    end else if (!st.atrArm && !rxStart && st.atrCnt == 16'h0000) begin
      nx.atrCnt = 16'h0000;
    end
    // card reset release
    nx.rlCnt = st.etuTick ? st.rlCnt + 8'h01 : st.rlCnt;
    case (st.rstSt)
      sct_pkg::RS_HOLD: begin
        nx.rlCnt = 8'h00;
        if (relOk) begin
          if (st.rlen == 8'h00) begin
            nx.rstSt = sct_pkg::RS_RUN;
            nx.tsArm = st.ctrl[sct_pkg::CTRL_FCDET];
            nx.tsCnt = 8'h00;
          end else begin
            nx.rstSt = sct_pkg::RS_DELAY;
          end
        end
      end
      sct_pkg::RS_DELAY: begin
        if (!relOk) begin
          nx.rstSt = sct_pkg::RS_HOLD;
        end else if (st.etuTick && st.rlCnt + 8'h01 >= st.rlen) begin
          nx.rstSt = sct_pkg::RS_RUN;
          nx.tsArm = st.ctrl[sct_pkg::CTRL_FCDET];
          nx.tsCnt = 8'h00;
        end
      end
      sct_pkg::RS_RUN: begin
        if (!relOk) begin
          nx.rstSt = sct_pkg::RS_HOLD;
          nx.tsArm = 1'b0;
        end
      end
      default: nx.rstSt = sct_pkg::RS_HOLD;
    endcase
    // sticky status: a new event wins over a clear in the same cycle
    setStat = {nx.evt.firstCharTo, nx.evt.answerTo, nx.evt.charTo, nx.evt.waitTo};
    if (wr && hit && idx == sct_pkg::IDX_STAT) begin
      nx.stat = (st.stat & ~apbReq.pwdata[3:0]) | setStat;
    end else begin
      nx.stat = st.stat | setStat;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st        <= '0;
      st.block_guard_time    <= sct_pkg::RST_BGT;
      st.egtLo  <= sct_pkg::RST_EGT;
      st.rlen   <= sct_pkg::RST_RLEN;
      st.etuDiv <= sct_pkg::RST_ETUDIV;
      st.rxGap  <= 9'h1FF;
      st.txGap  <= 9'h1FF;
      st.rstSt  <= sct_pkg::RS_HOLD;
    end else begin
      st <= nx;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_hold_low;
    st.ctrl[sct_pkg::CTRL_HOLD] |=> !cardRstn;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("reset not held");

  property p_zero_delay;
    st.rstSt == sct_pkg::RS_HOLD && relOk && st.rlen == 8'h00 |=> cardRstn;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("no direct release");

  property p_min_guard;
    txAllow |-> st.txGap >= (t1 ? 9'h00B : 9'h00C);
  endproperty
  a_min_guard: assert property (p_min_guard) else $error("spacing under floor");

  property p_block_guard;
    txAllow && st.lastRx |-> st.rxGap >= {4'h0, st.block_guard_time[4:0]};
  endproperty
  a_block_guard: assert property (p_block_guard) else $error("block guard broken");

  property p_char_to;
    st.evt.charTo |-> $past(st.cwtCnt) == $past(st.char_wait_limit) && $past(st.etuTick);
  endproperty
  a_char_to: assert property (p_char_to) else $error("char timeout early");

  property p_t1_wait;
    t1 && rxStart ##1 !txStart [*2] |-> !st.evt.waitTo;
  endproperty
  a_t1_wait: assert property (p_t1_wait) else $error("wait timer not stopped");

  property p_ans_off;
    !st.ctrl[sct_pkg::CTRL_ANS] |=> !st.atrArm && st.atrCnt == 16'h0000;
  endproperty
  a_ans_off: assert property (p_ans_off) else $error("answer timer live");

  property p_delay_len;
    $rose(cardRstn) |-> $past(st.rlen) == 8'h00 || $past(st.rlCnt) + 8'h01 >= $past(st.rlen);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("reset released early");

  property p_tx_restart;
    txStart |=> st.txGap == 9'h000;
  endproperty
  a_tx_restart: assert property (p_tx_restart) else $error("tx gap not cleared");

  property p_rx_restart;
    rxStart |=> st.rxGap == 9'h000 && st.lastRx;
  endproperty
  a_rx_restart: assert property (p_rx_restart) else $error("rx gap not cleared");

  property p_break_t0;
    !t1 && breakSeen |=> st.txGap == 9'h000;
  endproperty
  a_break_t0: assert property (p_break_t0) else $error("break ignored");

  property p_egt_floor;
    txAllow |-> st.txGap >= {st.block_guard_time[sct_pkg::BGT_EGT8], st.egtLo};
  endproperty
  a_egt_floor: assert property (p_egt_floor) else $error("extra guard broken");

  property p_mute_pair;
    st.evt.firstCharTo |-> st.evt.answerTo;
  endproperty
  a_mute_pair: assert property (p_mute_pair) else $error("mute without answer timeout");

  property p_ans_arm;
    rxStart && st.ctrl[sct_pkg::CTRL_ANS] && !st.atrArm && st.atrCnt == 16'h0000
      |=> st.atrArm && st.atrCnt == 16'h0000;
  endproperty
  a_ans_arm: assert property (p_ans_arm) else $error("answer timer not started");

  property p_t0_wait_arm;
    !t1 && rxStart |=> st.bwtArm && st.bwtCnt == 28'h000_0000;
  endproperty
  a_t0_wait_arm: assert property (p_t0_wait_arm) else $error("work wait not armed");

  property p_supply_lost;
    !st.supSync |=> !cardRstn;
  endproperty
  a_supply_lost: assert property (p_supply_lost) else $error("reset released unpowered");

  property p_tick_phase;
    st.etuTick |-> st.divCnt == 13'h0000;
  endproperty
  a_tick_phase: assert property (p_tick_phase) else $error("tick out of phase");
endmodule : sct_etu_guard
`default_nettype wire

/* File: bench/sct_card_model.sv */
`default_nettype none
module sct_card_model #(
  parameter int ETU_CYC = 4
) (
  // clock
  input  wire logic core_clk,
  // request from the bench
  input  wire logic sendStart,
  // card I/O line
  output logic      ioLine
);
  timeunit 1ns;
  timeprecision 1ps;
  int holdCnt = 0;
  // only the start bit falls; data bits are all ones, so one edge per character
  always @(posedge core_clk) begin
    if (sendStart) begin
      holdCnt <= ETU_CYC;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  // released line sits at the pull-up level
  assign ioLine = (holdCnt > 0) ? 1'b0 : 1'b1;
endmodule : sct_card_model
`default_nettype wire

/* File: bench/test_smartcard_etu_timing_guard.sv */
`default_nettype none
module test_smartcard_etu_timing_guard;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  logic                     core_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     txBusy = 1'b0;
  logic                     txStart = 1'b0;
  logic                     breakSeen = 1'b0;
  logic                     supplyGood = 1'b0;
  logic                     cardGo = 1'b0;
  sct_pkg::sct_apb_req_type apbReq = '0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     ioIn;
  logic                     cardRstn;
  logic                     txAllow;
  sct_pkg::sct_event_type   events;
  int                       error_cnt = 0;
  int                       num_checks = 0;
  logic [31:0]              rd;
  logic                     err;

  sct_etu_guard dut_u (.core_clk(core_clk), .rstn(rstn), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ioIn(ioIn), .cardSupplyGood(supplyGood),
    .cardRstn(cardRstn), .txBusy(txBusy), .txStart(txStart), .breakSeen(breakSeen),
    .txAllow(txAllow), .events(events));
  sct_card_model #(.ETU_CYC(DIV)) card_u (.core_clk(core_clk), .sendStart(cardGo),
    .ioLine(ioIn));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task close_out;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task rdc(input logic [15:0] idx, input logic [31:0] exp, input logic expErr);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, expErr});
  endtask : rdc

  task pulse(input int s);
    @(posedge core_clk);
    if (s == 0) txStart <= 1'b1;
    else if (s == 1) breakSeen <= 1'b1;
    else cardGo <= 1'b1;
    @(posedge core_clk);
    txStart <= 1'b0;
    breakSeen <= 1'b0;
    cardGo <= 1'b0;
  endtask : pulse

  function automatic logic pick(input int s);
    case (s)
      0: pick = txAllow;
      1: pick = cardRstn;
      2: pick = events.charTo;
      3: pick = events.waitTo;
      4: pick = events.answerTo;
      5: pick = events.firstCharTo;
      default: pick = ~cardRstn;
    endcase
  endfunction : pick

  // cycles until the chosen output is high, judged against a window
  task meas(input int s, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (pick(s) !== 1'b1 && n < hi + 50);
    num_checks++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("[ERR] %0t got %0h exp %0h", $time, n, lo);
    end
  endtask : meas

  task t_regs;
    logic [15:0] idx [12];
    logic [7:0]  rst [12];
    idx = '{sct_pkg::IDX_BGT, sct_pkg::IDX_EGT, sct_pkg::IDX_BWT3, sct_pkg::IDX_BWT2,
      sct_pkg::IDX_BWT1, sct_pkg::IDX_BWT0, sct_pkg::IDX_CWT1, sct_pkg::IDX_CWT0,
      sct_pkg::IDX_ATR1, sct_pkg::IDX_ATR0, sct_pkg::IDX_FIRST_CHAR_TIMEOUT_LIMIT, sct_pkg::IDX_RLEN};
    rst = '{sct_pkg::RST_BGT, sct_pkg::RST_EGT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, sct_pkg::RST_RLEN};
    for (int i = 0; i < 12; i++) rdc(idx[i], {24'h0, rst[i]}, 1'b0);
    rdc(sct_pkg::IDX_CTRL, 32'h0000_0000, 1'b0);
    rdc(sct_pkg::IDX_STAT, 32'h0000_0020, 1'b0);
    rdc(sct_pkg::IDX_ETUDIV, {19'h0, sct_pkg::RST_ETUDIV}, 1'b0);
    rdc(16'hFE1E, 32'h0000_0000, 1'b1);
    wr(sct_pkg::IDX_BWT3, 32'h0000_00FF);
    rdc(sct_pkg::IDX_BWT3, 32'h0000_000F, 1'b0);
    wr(sct_pkg::IDX_BWT3, 32'h0000_0000);
  endtask : t_regs

  task t_reset;
    wr(sct_pkg::IDX_ETUDIV, DIV);
    supplyGood <= 1'b1;
    meas(1, 440, 465);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0008);
    meas(6, 1, 4);
    wr(sct_pkg::IDX_RLEN, 32'h0000_0000);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0000);
    meas(1, 1, 4);
    @(posedge core_clk);
    supplyGood <= 1'b0;
    wr(sct_pkg::IDX_CTRL, 32'h0000_0008);
    supplyGood <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk({31'h0, cardRstn}, 32'h0);
    wr(sct_pkg::IDX_RLEN, 32'h0000_0005);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0000);
    meas(1, 14, 28);
  endtask : t_reset

  task t_guard;
    wr(sct_pkg::IDX_EGT, 32'h0000_0000);
    pulse(0);
    meas(0, 44, 52);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0001);
    pulse(0);
    meas(0, 40, 48);
    wr(sct_pkg::IDX_EGT, 32'h0000_0014);
    pulse(0);
    meas(0, 76, 84);
    wr(sct_pkg::IDX_BGT, 32'h0000_0096);
    wr(sct_pkg::IDX_EGT, 32'h0000_0000);
    pulse(0);
    meas(0, 1020, 1028);
    wr(sct_pkg::IDX_BGT, 32'h0000_0016);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0000);
    pulse(0);
    repeat (20) @(posedge core_clk);
    pulse(1);
    meas(0, 44, 52);
    pulse(2);
    repeat (5) @(posedge core_clk);
    meas(0, 76, 96);
  endtask : t_guard

  task t_waits;
    wr(sct_pkg::IDX_CWT0, 32'h0000_000A);
    pulse(2);
    meas(2, 40, 56);
    wr(sct_pkg::IDX_BWT0, 32'h0000_0014);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0001);
    pulse(0);
    meas(3, 80, 92);
    wr(sct_pkg::IDX_STAT, 32'h0000_0001);
    pulse(0);
    pulse(2);
    repeat (120) @(posedge core_clk);
    apb(1'b0, sct_pkg::IDX_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0000);
    pulse(2);
    meas(3, 80, 96);
    wr(sct_pkg::IDX_ATR0, 32'h0000_0006);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0002);
    pulse(2);
    meas(4, 26, 40);
    wr(sct_pkg::IDX_FIRST_CHAR_TIMEOUT_LIMIT, 32'h0000_0008);
    wr(sct_pkg::IDX_RLEN, 32'h0000_0000);
    wr(sct_pkg::IDX_CTRL, 32'h0000_000C);
    wr(sct_pkg::IDX_CTRL, 32'h0000_0004);
    meas(5, 30, 44);
    chk({31'h0, events.answerTo}, 32'h1);
    repeat (100) @(posedge core_clk);
    apb(1'b0, sct_pkg::IDX_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_001F, 32'h0000_001F);
    wr(sct_pkg::IDX_STAT, 32'h0000_000F);
    txBusy <= 1'b1;
    pulse(2);
    repeat (60) @(posedge core_clk);
    txBusy <= 1'b0;
    apb(1'b0, sct_pkg::IDX_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_001F, 32'h0000_0010);
  endtask : t_waits

  // the span covers all scenarios with ample margin
  initial begin
    #200000;
    error_cnt++;
    close_out;
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs;
    t_reset;
    t_guard;
    t_waits;
    close_out;
  end
endmodule : test_smartcard_etu_timing_guard
`default_nettype wire
